// >>> core/twi_host.sv
// Two-wire bus master driving the device through its clock and data pins
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Data changes only while clock is low
// - Start and stop are data edges, clock high
// - No start while another master holds bus
// - Repeated start allowed while owning bus
// - Address packet: seven bits, direction, acknowledge
// - Direction one reads, zero writes
// - Addressed slave pulls data low on ninth
// - After address nack only stop or start
// - Address sent most significant bit first
// - All-zero address with write is general call
// - Never general call with read direction
// - Addresses 1111xxx are reserved
// - Data packet: byte then acknowledge, nine clocks
// - Master makes clock, start, stop; receiver acks
// - Receiver nacks its last byte
// - Start directly followed by stop is illegal
// - Wait while slave holds clock low
// - Lines open-drain, only ever pulled low
// - Lose arbitration on high driven, low read; code checks this on address and data bits of writes only
module twi_host
  import twi_host_pkg::*;
#(
  parameter int QUARTER = twi_host_pkg::QUARTER_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Command
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire twi_host_pkg::cmd_e cmd_code,
  input  wire logic [7:0]        cmd_data,
  input  wire logic              cmd_nack,
  // Answer
  output var  logic              done,
  output var  logic              refused,
  output var  logic              arb_lost,
  output var  logic              ack_seen,
  output var  logic [7:0]        rd_data,
  output var  logic              bus_busy,
  output var  logic              owner,
  // Bus clock line
  input  wire logic              scl_i,
  output logic                   scl_o,
  output var  logic              scl_oe,
  // Bus data line
  input  wire logic              sda_i,
  output logic                   sda_o,
  output var  logic              sda_oe
);
  import twi_host_pkg::*;

  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(QUARTER - 1);

  phase_e     state;
  cmd_e       kind;
  logic [7:0] shifter;
  logic [3:0] bit_cnt;
  logic       nack_bit;
  logic       after_start;
  logic       addr_nack;
  logic       sda_q;
  logic       scl_s;
  logic       sda_s;
  logic       tmr_load;
  logic       tmr_exp;

  // ****************************************
  // Line synchronisers and phase timer
  // ****************************************
  // sync before detect
  line_sync #(.N(2)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({scl_i, sda_i}),
    .sync_out ({scl_s, sda_s})
  );

  bit_timer #(.W(TMR_W)) u_tmr (
    .clk      (clk),
    .reset    (reset),
    .load     (tmr_load),
    .load_val (TMR_LOAD),
    .expired  (tmr_exp)
  );

  // ****************************************
  // Decoding
  // ****************************************
  // pull low only
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  wire is_start = (cmd_code == CMD_START);
  wire is_stop  = (cmd_code == CMD_STOP);
  wire is_write = (cmd_code == CMD_WRITE);
  wire is_read  = (cmd_code == CMD_READ);
  wire is_xfer  = is_write | is_read;
  wire gc_read  = (cmd_data[7:1] == GCALL_ADDR) && (cmd_data[0] == DIR_READ);
  wire rsvd     = (cmd_data[7:4] == RSVD_PREFIX);
  wire bad_stop = is_stop && (!owner || after_start);
  wire bad_xfer = is_xfer && (!owner || addr_nack || (is_read && after_start));
  wire bad_addr = is_write && after_start && (gc_read || rsvd);
  wire refuse   = bad_stop || bad_xfer || bad_addr;
  wire blocked  = is_start && bus_busy && !owner;
  assign cmd_ready = (state == ST_IDLE) && !blocked;
  wire take     = cmd_valid && cmd_ready;
  wire go       = take && !refuse;

  wire ack_slot = (bit_cnt == LAST_BIT);
  // Level during low phase and first half of high phase
  wire lvl_first  = (kind == CMD_START) ? 1'b1 :
                    (kind == CMD_STOP)  ? 1'b0 :
                    (kind == CMD_WRITE) ? (ack_slot | shifter[7]) :
                    (ack_slot ? nack_bit : 1'b1);
  wire lvl_second = (kind == CMD_START) ? 1'b0 :
                    (kind == CMD_STOP)  ? 1'b1 : lvl_first;
  wire lost = (state == ST_HIGH1) && tmr_exp && (kind == CMD_WRITE)
              && !ack_slot && lvl_first && !sda_s;
  wire last_fall = (state == ST_FALL) && tmr_exp && ((kind == CMD_START) || ack_slot);
  wire stop_end  = (state == ST_HIGH2) && tmr_exp && (kind == CMD_STOP);
  wire rise_ok   = (state == ST_RISE) && scl_s;
  assign tmr_load = go || rise_ok || (tmr_exp && (state == ST_HIGH1 || state == ST_HIGH2
                    || state == ST_FALL || state == ST_LOW));

  // ****************************************
  // Bus condition detector
  // ****************************************
  wire start_seen = scl_s && sda_q && !sda_s;
  wire stop_seen  = scl_s && !sda_q && sda_s;

  always_ff @(posedge clk)
  begin
    if (reset)
      sda_q <= 1'b1;
    else
      sda_q <= sda_s;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      bus_busy <= 1'b0;
    else if (start_seen)
      bus_busy <= 1'b1;
    else if (stop_seen)
      bus_busy <= 1'b0;
  end

  // ****************************************
  // Bit sequencer
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state   <= ST_IDLE;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
      bit_cnt <= 4'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          bit_cnt <= 4'h0;
          if (go)
            state <= (is_start && !owner) ? ST_RISE : ST_LOW;
        end
        ST_LOW:
        begin
          sda_oe <= ~lvl_first;
          if (tmr_exp)
          begin
            scl_oe <= 1'b0;
            state  <= ST_RISE;
          end
        end
        ST_RISE:
          if (scl_s)
            state <= ST_HIGH1;
        ST_HIGH1:
          if (lost)
          begin
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            state  <= ST_IDLE;
          end
          else if (tmr_exp)
          begin
            sda_oe <= ~lvl_second;
            state  <= ST_HIGH2;
          end
        ST_HIGH2:
          if (tmr_exp)
          begin
            scl_oe <= (kind != CMD_STOP);
            state  <= (kind == CMD_STOP) ? ST_IDLE : ST_FALL;
          end
        ST_FALL:
          if (tmr_exp)
          begin
            state   <= last_fall ? ST_IDLE : ST_LOW;
            bit_cnt <= last_fall ? 4'h0 : bit_cnt + 4'h1;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Data path
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      kind     <= CMD_START;
      shifter  <= 8'h00;
      nack_bit <= 1'b0;
      ack_seen <= 1'b1;
      rd_data  <= 8'h00;
    end
    else if (go)
    begin
      kind     <= cmd_code;
      shifter  <= cmd_data;
      nack_bit <= cmd_nack;
    end
    else if (state == ST_HIGH1 && tmr_exp)
    begin
      if (ack_slot)
        ack_seen <= sda_s;
      else if (kind == CMD_READ)
        shifter <= {shifter[6:0], sda_s};
    end
    else if (state == ST_FALL && tmr_exp)
    begin
      if (kind == CMD_WRITE && !ack_slot)
        shifter <= {shifter[6:0], 1'b0};
      if (kind == CMD_READ && ack_slot)
        rd_data <= shifter;
    end
  end

  // ****************************************
  // Ownership and answers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      owner       <= 1'b0;
      after_start <= 1'b0;
      addr_nack   <= 1'b0;
      done        <= 1'b0;
      refused     <= 1'b0;
      arb_lost    <= 1'b0;
    end
    else
    begin
      done     <= (take && refuse) || lost || last_fall || stop_end;
      refused  <= take && refuse;
      arb_lost <= lost;
      if (go && is_start)
        owner <= 1'b1;
      else if (lost || stop_end)
        owner <= 1'b0;
      if (last_fall && kind == CMD_START)
      begin
        after_start <= 1'b1;
        addr_nack   <= 1'b0;
      end
      else if (last_fall && kind == CMD_WRITE)
      begin
        after_start <= 1'b0;
        if (after_start)
          addr_nack <= ack_seen;
      end
      else if (lost || stop_end)
      begin
        after_start <= 1'b0;
        addr_nack   <= 1'b0;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence seq_stop_take;
    take && is_stop && after_start;
  endsequence
  sequence seq_refuse_shown;
    refused && done && owner;
  endsequence

  chk_data_stable_high: assert property (
    (state == ST_HIGH1) && !lost |=> $stable(sda_oe) || (state == ST_HIGH2))
    else $error("data moved while clock high");
  chk_start_edge: assert property (
    (state == ST_HIGH2) && (kind == CMD_START) |-> sda_oe && !scl_oe)
    else $error("start edge missing");
  chk_no_steal: assert property (
    take && is_start && bus_busy |-> owner)
    else $error("start taken on busy bus");
  chk_msb_first: assert property (
    (state == ST_LOW) && (kind == CMD_WRITE) && !ack_slot ##1 (state == ST_LOW)
    |-> sda_oe == !$past(shifter[7]))
    else $error("write bit not msb first");
  chk_nine_clocks: assert property (
    last_fall && (kind != CMD_START) |-> bit_cnt == LAST_BIT)
    else $error("packet not nine clocks");
  chk_gc_read: assert property (
    take && is_write && after_start && gc_read |=> seq_refuse_shown)
    else $error("general call read not refused");
  chk_empty_msg: assert property (
    seq_stop_take |=> refused ##1 !done)
    else $error("empty message not refused");
  chk_nack_follow: assert property (
    take && is_xfer && addr_nack |=> refused)
    else $error("transfer after address nack");
  chk_stretch_wait: assert property (
    (state == ST_RISE) && !scl_s |=> (state == ST_RISE) && !scl_oe)
    else $error("clock stretch ignored");
  chk_arb_release: assert property (
    lost |=> arb_lost && !sda_oe && !scl_oe && !owner)
    else $error("lines kept after lost arbitration");
  chk_high_time: assert property (
    $rose(state == ST_HIGH1) |-> (state == ST_HIGH1) [*8])
    else $error("clock high too short");

endmodule

`default_nettype wire

// >>> core/twi_host_pkg.sv
// Constants and types for the two-wire bus master
package twi_host_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ     = 100_000_000;
  localparam int SCL_MAX_HZ = 400_000;
  // Quarter of the bus clock period, rounded up so the rate never exceeds the limit
  localparam int QUARTER_CYC = (CLK_HZ + 4 * SCL_MAX_HZ - 1) / (4 * SCL_MAX_HZ);
  localparam int TMR_W       = 8;

  // ****************************************
  // Framing
  // ****************************************
  localparam logic [3:0] LAST_BIT    = 4'h8;
  localparam logic [6:0] GCALL_ADDR  = 7'h00;
  localparam logic [3:0] RSVD_PREFIX = 4'hF;
  localparam logic       DIR_READ    = 1'b1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0]
  {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ  = 2'h2,
    CMD_STOP  = 2'h3
  } cmd_e;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h0,
    ST_LOW   = 3'h1,
    ST_RISE  = 3'h3,
    ST_HIGH1 = 3'h2,
    ST_HIGH2 = 3'h6,
    ST_FALL  = 3'h7
  } phase_e;

endpackage

// >>> core/line_sync.sv
// Two-stage synchroniser for the bus lines
`timescale 1ns/1ps
`default_nettype none

module line_sync #(
  parameter int N = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Lines
  input  wire logic [N-1:0] async_in,
  output var  logic [N-1:0] sync_out
);

  logic [N-1:0] meta;

  // ****************************************
  // One pair of flops per line
  // ****************************************
  for (genvar i = 0; i < N; i++)
  begin : g_line
    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        meta[i]     <= 1'b1;
        sync_out[i] <= 1'b1;
      end
      else
      begin
        meta[i]     <= async_in[i];
        sync_out[i] <= meta[i];
      end
    end
  end

endmodule

`default_nettype wire

// >>> core/bit_timer.sv
// Down counter timing the phases of one bus bit
`timescale 1ns/1ps
`default_nettype none

module bit_timer #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              expired
);

  logic [W-1:0] count;

  assign expired = (count == '0);

  always_ff @(posedge clk)
  begin
    if (reset)
      count <= '0;
    else if (load)
      count <= load_val;
    else if (!expired)
      count <= count - 1'b1;
  end

endmodule

`default_nettype wire

// >>> test/twi_slave_model.sv
// Behavioural slave device on the two-wire bus
`timescale 1ns/1ps
`default_nettype none

module twi_slave_model #(
  parameter logic [6:0] OWN_ADDR = 7'h2A,
  parameter logic       GCALL_EN = 1'b1
) (
  // Bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  output var  logic       scl_oe,
  output var  logic       sda_oe,
  // Test control
  input  wire logic [7:0] tx_byte,
  input  var  int         stretch_ns,
  output var  logic [7:0] rx_byte
);
  logic [7:0] sh;
  logic [3:0] cnt;
  logic       addr_ph;
  logic       sel;
  logic       rd;
  logic       drv;

  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    rx_byte = 8'h00;
    sh = 8'h00;
    cnt = 4'h0;
    addr_ph = 1'b0;
    sel = 1'b0;
    rd = 1'b0;
  end

  always @(negedge sda)
    if (scl === 1'b1)
    begin
      cnt = 4'h0;
      addr_ph = 1'b1;
      sel = 1'b0;
    end

  always @(posedge sda)
    if (scl === 1'b1)
    begin
      addr_ph = 1'b0;
      sel = 1'b0;
    end

  always @(posedge scl)
  begin
    if (cnt < 4'h8)
      sh = {sh[6:0], sda};
    else if (sel && rd && sda)
      sel = 1'b0;
    cnt = cnt + 4'h1;
  end

  always @(negedge scl)
  begin
    drv = 1'b0;
    if (cnt == 4'h9)
      cnt = 4'h0;
    if (cnt == 4'h8 && addr_ph)
    begin
      addr_ph = 1'b0;
      rd = sh[0];
      sel = (sh[7:1] == OWN_ADDR) || (GCALL_EN && sh == 8'h00);
      drv = sel;
    end
    else if (cnt == 4'h8 && sel && !rd)
    begin
      rx_byte = sh;
      drv = 1'b1;
    end
    else if (sel && rd && cnt < 4'h8)
      drv = ~tx_byte[3'h7 - cnt[2:0]];
    sda_oe = drv;
  end

  always @(negedge scl)
    if (stretch_ns > 0)
    begin
      scl_oe = 1'b1;
      #(stretch_ns);
      scl_oe = 1'b0;
    end

endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the two-wire bus master
`timescale 1ns/1ps
`default_nettype none

module tb;
  import twi_host_pkg::*;
  localparam int         Q   = 9;
  localparam logic [6:0] SLV = 7'h2A;
  logic       clk;
  logic       reset;
  logic       cmd_valid;
  logic       cmd_ready;
  cmd_e       cmd_code;
  logic [7:0] cmd_data;
  logic       cmd_nack;
  logic       done;
  logic       refused;
  logic       arb_lost;
  logic       ack_seen;
  logic [7:0] rd_data;
  logic       bus_busy;
  logic       owner;
  logic       scl_oe;
  logic       sda_oe;
  logic       scl_out;
  logic       sda_out;
  logic       s_scl_oe;
  logic       s_sda_oe;
  logic       x_sda;
  logic [7:0] tx_byte;
  int         stretch_ns;
  logic [7:0] rx_byte;
  logic       got_arb;
  int         errors;
  int         tests_run;
  wire logic  scl = ~((scl_oe & ~scl_out) | s_scl_oe);
  wire logic  sda = ~((sda_oe & ~sda_out) | s_sda_oe | x_sda);

  twi_host #(.QUARTER(Q)) twi_host_inst (
    .clk       (clk),
    .reset     (reset),
    .cmd_valid (cmd_valid),
    .cmd_ready (cmd_ready),
    .cmd_code  (cmd_code),
    .cmd_data  (cmd_data),
    .cmd_nack  (cmd_nack),
    .done      (done),
    .refused   (refused),
    .arb_lost  (arb_lost),
    .ack_seen  (ack_seen),
    .rd_data   (rd_data),
    .bus_busy  (bus_busy),
    .owner     (owner),
    .scl_i     (scl),
    .scl_o     (scl_out),
    .scl_oe    (scl_oe),
    .sda_i     (sda),
    .sda_o     (sda_out),
    .sda_oe    (sda_oe)
  );

  twi_slave_model #(.OWN_ADDR(SLV)) twi_slave_model_inst (
    .scl        (scl),
    .sda        (sda),
    .scl_oe     (s_scl_oe),
    .sda_oe     (s_sda_oe),
    .tx_byte    (tx_byte),
    .stretch_ns (stretch_ns),
    .rx_byte    (rx_byte)
  );

  always #5 clk = ~clk;

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmd(input cmd_e c, input logic [7:0] d, input logic n, input logic ref_exp);
    int k;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = d;
    cmd_nack = n;
    k = 0;
    #1;
    while (cmd_ready !== 1'b1 && k < 1000)
    begin
      @(negedge clk);
      #1;
      k++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 5000)
    begin
      @(negedge clk);
      k++;
    end
    got_arb = arb_lost;
    chk("done", 8'h01, 8'(done));
    chk("refused", 8'(ref_exp), 8'(refused));
  endtask

  task automatic t_write;
    cmd(CMD_START, 8'h00, 1'b0, 1'b0);
    chk("busy", 8'h01, 8'(bus_busy));
    cmd(CMD_WRITE, {SLV, 1'b0}, 1'b0, 1'b0);
    chk("addr ack", 8'h00, 8'(ack_seen));
    cmd(CMD_WRITE, 8'hA5, 1'b0, 1'b0);
    chk("data ack", 8'h00, 8'(ack_seen));
    chk("rx byte", 8'hA5, rx_byte);
    cmd(CMD_STOP, 8'h00, 1'b0, 1'b0);
    repeat (8) @(negedge clk);
    chk("idle", 8'h00, 8'(bus_busy));
  endtask

  task automatic t_read;
    stretch_ns = 300;
    tx_byte = 8'h3C;
    cmd(CMD_START, 8'h00, 1'b0, 1'b0);
    cmd(CMD_WRITE, {SLV, 1'b1}, 1'b0, 1'b0);
    chk("read ack", 8'h00, 8'(ack_seen));
    cmd(CMD_READ, 8'h00, 1'b0, 1'b0);
    chk("rd byte 1", 8'h3C, rd_data);
    cmd(CMD_READ, 8'h00, 1'b1, 1'b0);
    chk("rd byte 2", 8'h3C, rd_data);
    cmd(CMD_STOP, 8'h00, 1'b0, 1'b0);
    stretch_ns = 0;
  endtask

  task automatic t_refuse;
    cmd(CMD_WRITE, {SLV, 1'b0}, 1'b0, 1'b1);
    cmd(CMD_START, 8'h00, 1'b0, 1'b0);
    cmd(CMD_STOP, 8'h00, 1'b0, 1'b1);
    cmd(CMD_WRITE, {7'h50, 1'b0}, 1'b0, 1'b0);
    chk("nack", 8'h01, 8'(ack_seen));
    cmd(CMD_WRITE, 8'h11, 1'b0, 1'b1);
    cmd(CMD_START, 8'h00, 1'b0, 1'b0);
    chk("owner", 8'h01, 8'(owner));
    cmd(CMD_READ, 8'h00, 1'b0, 1'b1);
    cmd(CMD_WRITE, 8'h01, 1'b0, 1'b1);
    cmd(CMD_WRITE, 8'hF0, 1'b0, 1'b1);
    cmd(CMD_WRITE, 8'h00, 1'b0, 1'b0);
    chk("gcall ack", 8'h00, 8'(ack_seen));
    cmd(CMD_WRITE, 8'h5A, 1'b0, 1'b0);
    chk("gcall data", 8'h5A, rx_byte);
    cmd(CMD_STOP, 8'h00, 1'b0, 1'b0);
  endtask

  task automatic t_busy;
    x_sda = 1'b1;
    repeat (10) @(negedge clk);
    chk("other busy", 8'h01, 8'(bus_busy));
    cmd_code = CMD_START;
    cmd_valid = 1'b1;
    repeat (20) @(negedge clk);
    chk("start held", 8'h00, 8'(cmd_ready));
    chk("not owner", 8'h00, 8'(owner));
    cmd_valid = 1'b0;
    x_sda = 1'b0;
    repeat (10) @(negedge clk);
    chk("other free", 8'h00, 8'(bus_busy));
  endtask

  task automatic t_arb;
    cmd(CMD_START, 8'h00, 1'b0, 1'b0);
    x_sda = 1'b1;
    cmd(CMD_WRITE, {SLV, 1'b0}, 1'b0, 1'b0);
    chk("arb lost", 8'h01, 8'(got_arb));
    chk("lines", 8'h00, 8'({scl_oe, sda_oe}));
    chk("lost owner", 8'h00, 8'(owner));
    x_sda = 1'b0;
    repeat (10) @(negedge clk);
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #500_000;
    errors++;
    give_verdict;
  end

  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_code = CMD_START;
    cmd_data = 8'h00;
    cmd_nack = 1'b0;
    x_sda = 1'b0;
    tx_byte = 8'h00;
    stretch_ns = 0;
    got_arb = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    chk("reset ack", 8'h01, 8'(ack_seen));
    chk("reset lines", 8'h00, 8'({scl_oe, sda_oe, owner, bus_busy}));
    chk("drive level", 8'h00, 8'({scl_out, sda_out}));
    t_write;
    t_read;
    t_refuse;
    t_busy;
    t_arb;
    give_verdict;
  end

endmodule
`default_nettype wire
